// [core/fmr_pkg.sv]
// Shared constants and carrier types for the host access and reset block.
// Assumes a single 40 MHz clock and host strobes already synchronous to it.
`default_nettype none

package fmr_pkg;

   // ---------------------------------------------------------------
   // Register selects on the host address lines
   // ---------------------------------------------------------------
   localparam logic [3:0] FMR_REG_CTRL0   = 4'h0;
   localparam logic [3:0] FMR_REG_CTRL1   = 4'h1;
   localparam logic [3:0] FMR_REG_CADDR_L = 4'h2;
   localparam logic [3:0] FMR_REG_CADDR_H = 4'h3;
   localparam logic [3:0] FMR_REG_COEF    = 4'h8;
   localparam logic [3:0] FMR_REG_THRESH  = 4'hE;
   localparam logic [3:0] FMR_REG_CORR    = 4'hF;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int FMR_C0_RESET       = 7;
   localparam int FMR_C0_SENS        = 6;
   localparam int FMR_C0_CONTACT_SENSOR_CORRECTION_SELECT       = 3;
   localparam int FMR_C0_SCAN        = 0;
   localparam int FMR_C1_ACCESS_EN   = 7;
   localparam int FMR_C1_BUS_SEL     = 4;
   localparam int FMR_C1_HALF_SPEED  = 1;
   localparam int FMR_C1_SLEEP       = 0;
   localparam int FMR_CH_LOAD        = 6;
   localparam int FMR_CL_ADDR_LSB    = 3;
   localparam int FMR_CH_ADDR_MSB    = 3;
   localparam int FMR_COEF_MSB       = 2;
   localparam int FMR_COEF_SHIFT     = 3;

   // ---------------------------------------------------------------
   // Sizes and reset values
   // ---------------------------------------------------------------
   localparam int FMR_DATA_W   = 8;
   localparam int FMR_PIX_W    = 5;
   localparam int FMR_THR_W    = 4;
   localparam int FMR_THR_N    = 16;
   localparam int FMR_THR_AW   = 4;
   localparam int FMR_CORR_W   = 5;
   localparam int FMR_CORR_N   = 304;
   localparam int FMR_CORR_AW  = 9;
   localparam int FMR_PER_W    = 8;
   localparam logic [7:0] FMR_REG_RST = 8'h00;
   localparam logic [2:0] FMR_COEF_RST = 3'h4;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
      logic       wr_n;
      logic       rd_n;
   } fmr_host_t;

   typedef struct packed {
      logic       line_sync;
      logic       pix_valid;
      logic [4:0] pixel;
      logic [4:0] background;
   } fmr_line_t;

endpackage

`default_nettype wire

// [core/fmr_word_mem.sv]
// Small word memory with one registered write port and an asynchronous read.
// Assumes the owner decodes strobes; out-of-range addresses write nothing and read zero.
`default_nettype none

module fmr_word_mem #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // Access
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    addr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   output logic      [WIDTH-1:0] rdata_o
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] word;
   } fmr_mem_state_t;

   fmr_mem_state_t st;
   fmr_mem_state_t next_st;
   logic           in_range;

   assign in_range = (32'(addr_i) < DEPTH);
   assign rdata_o  = in_range ? st.word[addr_i] : '0;

   always_comb begin
      next_st = st;
      if (we_i && in_range) begin
         next_st.word[addr_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

`default_nettype wire

// [core/fmr_host_port.sv]
// Host parallel port: control registers, threshold and correction memory access,
// resets, standby and line sequencing with half speed, peak tracking, bi-level threshold_coefficient.
// Assumes host strobes and line inputs are synchronous to clk_i.
//
// Contract
// - Reset bit write clears threshold address counter
// - Threshold write stores bits, advances on strobe
// - Threshold read drives word, advances on strobe
// - Sixteen four-bit words, row-major matrix
// - Register 3 holds A8..A5 and load flag
// - Correction write stores five bits at address
// - Correction read returns stored five-bit word
// - Hard reset clears all but coef (set to 4), includes others
// - Soft reset aborts line, resumes next line
// - Sleep stops internal clocked processing
// - Sleep keeps counter, registers; inits flops
// - Half speed samples once per two lines
// - Larger coefficient makes output darker
// - Peak tracking continues during line read
// - Contact sensor bit may bypass correction
// - Reset acts only while strobe low, bit set
`default_nettype none

module fmr_host_port
   import fmr_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   // Host bus
   input  wire fmr_host_t             host_i,
   output logic      [FMR_DATA_W-1:0] data_o,
   output logic                       data_oe_o,
   // Line path
   input  wire fmr_line_t             line_i,
   output logic                       line_active_o,
   output logic                       black_o,
   output logic      [FMR_PIX_W-1:0]  peak_o,
   output logic                       correction_apply_o,
   output logic      [FMR_PER_W-1:0]  period_count_o,
   output logic                       mem_standby_o,
   output logic                       soft_reset_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                   wr_q;
      logic                   rd_q;
      logic [3:0]             waddr;
      logic [FMR_DATA_W-1:0]  wdata;
      logic [FMR_DATA_W-1:0]  ctrl0;
      logic [FMR_DATA_W-1:0]  ctrl1;
      logic [FMR_DATA_W-1:0]  caddr_l;
      logic [FMR_DATA_W-1:0]  caddr_h;
      logic [2:0]             coef;
      logic [FMR_THR_AW-1:0]  thr_ptr;
      logic                   line_active;
      logic                   half_phase;
      logic [FMR_PER_W-1:0]   period;
      logic [FMR_PIX_W-1:0]   peak;
      logic [FMR_DATA_W-1:0]  dout;
      logic                   doe;
      logic                   black;
      logic                   corr_apply;
      logic                   soft_rst;
   } fmr_state_t;

   fmr_state_t st;
   fmr_state_t next_st;

   // ---------------------------------------------------------------
   // Strobe decode
   // ---------------------------------------------------------------
   logic                   wr_rise;
   logic                   rd_rise;
   logic                   soft_req;
   logic                   mem_mode;
   logic                   corr_en;
   logic                   sleep;
   logic                   scan;
   logic                   thr_we;
   logic                   corr_we;
   logic [FMR_THR_W-1:0]   thr_rdata;
   logic [FMR_CORR_W-1:0]  corr_rdata;
   logic [FMR_CORR_AW-1:0] corr_addr;
   logic [7:0]             threshold_coefficient_prod;

   // Write data is latched while the strobe is low and used at its rising edge
   assign wr_rise  = !st.wr_q && host_i.wr_n;
   assign rd_rise  = !st.rd_q && host_i.rd_n;
   assign mem_mode = !st.ctrl1[FMR_C1_BUS_SEL];
   assign corr_en  = mem_mode && st.ctrl1[FMR_C1_ACCESS_EN];
   assign sleep    = st.ctrl1[FMR_C1_SLEEP];
   assign scan     = st.ctrl0[FMR_C0_SCAN];
   // Level-sensitive: held for as long as the strobe stays low with bit 7 set
   assign soft_req = !host_i.wr_n && (host_i.addr == FMR_REG_CTRL0)
                     && host_i.data[FMR_C0_RESET];
   assign corr_addr = {st.caddr_h[FMR_CH_ADDR_MSB:0],
                       st.caddr_l[FMR_DATA_W-1:FMR_CL_ADDR_LSB]};
   assign thr_we   = wr_rise && (st.waddr == FMR_REG_THRESH) && mem_mode;
   assign corr_we  = wr_rise && (st.waddr == FMR_REG_CORR) && corr_en
                     && st.caddr_h[FMR_CH_LOAD];
   assign threshold_coefficient_prod = 8'(line_i.background) * (8'(st.coef) + 8'h01);

   // ---------------------------------------------------------------
   // Memories
   // ---------------------------------------------------------------
   fmr_word_mem #(
      .WIDTH (FMR_THR_W),
      .DEPTH (FMR_THR_N),
      .AW    (FMR_THR_AW)
   ) u_thr_mem (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .we_i     (thr_we),
      .addr_i   (st.thr_ptr),
      .wdata_i  (st.wdata[FMR_THR_W-1:0]),
      .rdata_o  (thr_rdata)
   );

   fmr_word_mem #(
      .WIDTH (FMR_CORR_W),
      .DEPTH (FMR_CORR_N),
      .AW    (FMR_CORR_AW)
   ) u_corr_mem (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .we_i     (corr_we),
      .addr_i   (corr_addr),
      .wdata_i  (st.wdata[FMR_CORR_W-1:0]),
      .rdata_o  (corr_rdata)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.wr_q     = host_i.wr_n;
      next_st.rd_q     = host_i.rd_n;
      next_st.soft_rst = soft_req;
      if (!host_i.wr_n) begin
         next_st.waddr = host_i.addr;
         next_st.wdata = host_i.data;
      end

      // Register writes land at the rising edge of the write strobe
      if (wr_rise) begin
         unique case (st.waddr)
            FMR_REG_CTRL0: begin
               next_st.ctrl0 = st.wdata & 8'h7F;
            end
            FMR_REG_CTRL1: begin
               next_st.ctrl1 = st.wdata;
            end
            FMR_REG_CADDR_L: begin
               next_st.caddr_l = st.wdata;
            end
            FMR_REG_CADDR_H: begin
               next_st.caddr_h = st.wdata;
            end
            FMR_REG_COEF: begin
               next_st.coef = st.wdata[FMR_COEF_MSB:0];
            end
            default: begin
            end
         endcase
      end

      // Threshold address counter; 4-bit width wraps 15 to 0
      if ((thr_we) || (rd_rise && (host_i.addr == FMR_REG_THRESH) && mem_mode)) begin
         next_st.thr_ptr = st.thr_ptr + 4'h1;
      end

      // Read data path, registered one cycle after the strobe is seen low
      next_st.doe  = !host_i.rd_n;
      next_st.dout = FMR_REG_RST;
      if (!host_i.rd_n) begin
         unique case (host_i.addr)
            FMR_REG_CTRL1: begin
               next_st.dout = st.ctrl1;
            end
            FMR_REG_CADDR_L: begin
               next_st.dout = st.caddr_l;
            end
            FMR_REG_CADDR_H: begin
               next_st.dout = st.caddr_h;
            end
            FMR_REG_COEF: begin
               next_st.dout = {5'h00, st.coef};
            end
            FMR_REG_THRESH: begin
               if (mem_mode) begin
                  next_st.dout = {4'h0, thr_rdata};
               end
            end
            FMR_REG_CORR: begin
               if (corr_en) begin
                  next_st.dout = {3'h0, corr_rdata};
               end
            end
            default: begin
            end
         endcase
      end

      // Line sequencing; line_sync marks the start of each line period
      next_st.corr_apply = scan && !(st.ctrl0[FMR_C0_SENS] && st.ctrl0[FMR_C0_CONTACT_SENSOR_CORRECTION_SELECT]);
      if (line_i.line_sync) begin
         next_st.period = st.period + 8'h01;
         if (st.ctrl1[FMR_C1_HALF_SPEED]) begin
            next_st.half_phase  = !st.half_phase;
            next_st.line_active = scan && !st.half_phase;
         end else begin
            next_st.half_phase  = 1'b0;
            next_st.line_active = scan;
         end
      end
      if (st.line_active && line_i.pix_valid) begin
         if (line_i.pixel > st.peak) begin
            next_st.peak = line_i.pixel;
         end
         // Threshold scales background by (coef+1)/8: larger coef, more black
         next_st.black = ({3'h0, line_i.pixel} < (threshold_coefficient_prod >> FMR_COEF_SHIFT));
      end

      if (soft_req) begin
         next_st.thr_ptr     = '0;
         next_st.line_active = 1'b0;
      end

      // Standby freezes the line logic; the host port stays alive so it can wake us
      if (sleep) begin
         next_st.period      = st.period;
         next_st.line_active = 1'b0;
         next_st.half_phase  = 1'b0;
         next_st.peak        = '0;
         next_st.black       = 1'b0;
         next_st.thr_ptr     = '0;
         next_st.corr_apply  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st         <= '0;
         st.wr_q    <= 1'b1;
         st.rd_q    <= 1'b1;
         st.ctrl1   <= FMR_REG_RST;
         st.coef    <= FMR_COEF_RST;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign data_o             = st.dout;
   assign data_oe_o          = st.doe;
   assign line_active_o      = st.line_active;
   assign black_o            = st.black;
   assign peak_o             = st.peak;
   assign correction_apply_o = st.corr_apply;
   assign period_count_o     = st.period;
   assign mem_standby_o      = st.ctrl1[FMR_C1_SLEEP];
   assign soft_reset_o       = st.soft_rst;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_thr_clear;
      @(posedge clk_i) disable iff (!arst_n_i)
      soft_req |=> (st.thr_ptr == 4'h0);
   endproperty
   a_thr_clear: assert property (p_thr_clear)
      else $error("threshold counter not cleared by reset write");

   property p_thr_write_adv;
      @(posedge clk_i) disable iff (!arst_n_i)
      (thr_we && !soft_req && !sleep) |=> (st.thr_ptr == 4'($past(st.thr_ptr) + 4'h1));
   endproperty
   a_thr_write_adv: assert property (p_thr_write_adv)
      else $error("threshold counter did not advance on write");

   property p_thr_read_data;
      @(posedge clk_i) disable iff (!arst_n_i)
      (!host_i.rd_n && host_i.addr == FMR_REG_THRESH && mem_mode)
         |=> (data_o == {4'h0, $past(thr_rdata)}) && data_oe_o;
   endproperty
   a_thr_read_data: assert property (p_thr_read_data)
      else $error("threshold read data wrong");

   property p_thr_wrap;
      @(posedge clk_i) disable iff (!arst_n_i)
      (thr_we && st.thr_ptr == 4'hF && !soft_req && !sleep) |=> (st.thr_ptr == 4'h0);
   endproperty
   a_thr_wrap: assert property (p_thr_wrap)
      else $error("threshold counter did not wrap");

   property p_corr_store;
      @(posedge clk_i) disable iff (!arst_n_i)
      (corr_we && 32'(corr_addr) < FMR_CORR_N)
         |=> (corr_rdata == $past(st.wdata[FMR_CORR_W-1:0]));
   endproperty
   a_corr_store: assert property (p_corr_store)
      else $error("correction word not stored");

   property p_soft_abort;
      @(posedge clk_i) disable iff (!arst_n_i)
      soft_req |=> !line_active_o ##1 (!line_active_o || $past(line_i.line_sync));
   endproperty
   a_soft_abort: assert property (p_soft_abort)
      else $error("line not aborted by soft reset");

   property p_sleep_hold;
      @(posedge clk_i) disable iff (!arst_n_i)
      sleep |=> !line_active_o && (period_count_o == $past(period_count_o));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("standby did not hold counter or clear line state");

   property p_half_skip;
      @(posedge clk_i) disable iff (!arst_n_i)
      (line_i.line_sync && st.ctrl1[FMR_C1_HALF_SPEED] && st.half_phase) |=> !line_active_o;
   endproperty
   a_half_skip: assert property (p_half_skip)
      else $error("half speed sampled a skipped line");

   property p_peak_track;
      @(posedge clk_i) disable iff (!arst_n_i)
      (st.line_active && line_i.pix_valid && line_i.pixel > st.peak && !sleep)
         |=> (peak_o == $past(line_i.pixel));
   endproperty
   a_peak_track: assert property (p_peak_track)
      else $error("peak not tracked during line read");

   property p_bypass;
      @(posedge clk_i) disable iff (!arst_n_i)
      (st.ctrl0[FMR_C0_SENS] && st.ctrl0[FMR_C0_CONTACT_SENSOR_CORRECTION_SELECT]) |=> !correction_apply_o;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("correction applied while bypass selected");

endmodule

`default_nettype wire

// [tb/fmr_host_model.sv]
// Behavioural host processor on the parallel register bus of the host port.
// Assumes clk_i is the block clock; all strobes change just after a falling edge.
`default_nettype none

module fmr_host_model
   import fmr_pkg::*;
(
   // Clock
   input  wire logic                  clk_i,
   // Read return from the block
   input  wire logic [FMR_DATA_W-1:0] data_i,
   input  wire logic                  data_oe_i,
   // Host bus
   output var  fmr_host_t             host_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      host_o = '{addr: 4'h0, data: 8'h00, wr_n: 1'b1, rd_n: 1'b1};
   end

   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // One low cycle, one high cycle; address held until the rise is seen
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_i);
      host_o.addr = a;
      host_o.data = d;
      host_o.wr_n = 1'b0;
      @(negedge clk_i);
      host_o.wr_n = 1'b1;
      @(negedge clk_i);
      // Released bus shows the inverse, so stale data cannot match by luck
      host_o.data = ~d;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic oe);
      @(negedge clk_i);
      host_o.addr = a;
      host_o.rd_n = 1'b0;
      @(negedge clk_i);
      d = data_i;
      oe = data_oe_i;
      host_o.rd_n = 1'b1;
      @(negedge clk_i);
   endtask

   // ---------------------------------------------------------------
   // Correction memory setup
   // ---------------------------------------------------------------
   task automatic set_corr_addr(input logic [8:0] a, input logic load);
      wr(FMR_REG_CADDR_L, {a[4:0], 3'h0});
      wr(FMR_REG_CADDR_H, {1'b0, load, 2'h0, a[8:5]});
   endtask

   // Level counter speeds live outside this block; the model never writes them

   // Normal operation here keeps the bus select cleared
   task automatic corr_mode(input logic on);
      wr(FMR_REG_CTRL1, on ? 8'h80 : 8'h00);
   endtask

endmodule

`default_nettype wire

// [tb/tb_fmr_host_port.sv]
// Self-checking bench for the host port: registers, memories, resets, line path.
// Assumes the host model drives the bus and the bench drives the line inputs.
`default_nettype none

module tb_fmr_host_port
   import fmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 4000;

   logic                  clk_i    = 1'b0;
   logic                  arst_n_i = 1'b0;
   fmr_host_t             host;
   fmr_line_t             line     = '{line_sync: 1'b0, pix_valid: 1'b0, pixel: 5'h00,
                                      background: 5'h10};
   logic [FMR_DATA_W-1:0] data_o;
   logic                  data_oe_o;
   logic                  line_active_o;
   logic                  black_o;
   logic [FMR_PIX_W-1:0]  peak_o;
   logic                  correction_apply_o;
   logic [FMR_PER_W-1:0]  period_count_o;
   logic                  mem_standby_o;
   logic                  soft_reset_o;
   int                    error_cnt = 0;
   int                    compares  = 0;
   int                    cycles    = 0;

   always #12.5 clk_i = ~clk_i;

   fmr_host_port i_fmr_host_port (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .host_i(host), .data_o(data_o),
      .data_oe_o(data_oe_o), .line_i(line), .line_active_o(line_active_o),
      .black_o(black_o), .peak_o(peak_o), .correction_apply_o(correction_apply_o),
      .period_count_o(period_count_o), .mem_standby_o(mem_standby_o),
      .soft_reset_o(soft_reset_o)
   );

   fmr_host_model i_fmr_host_model (
      .clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe_o), .host_o(host)
   );

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       oe;
      i_fmr_host_model.rd(a, d, oe);
      chk(d, exp);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_fmr_host_model.wr(a, d);
   endtask

   task automatic line_step(input logic sync, input logic valid, input logic [4:0] pix);
      @(negedge clk_i);
      line.line_sync = sync;
      line.pix_valid = valid;
      line.pixel = pix;
      @(negedge clk_i);
      line.line_sync = 1'b0;
      line.pix_valid = 1'b0;
   endtask

   // Nonzero thresholds, last word differs from the first so a wrap shows
   function automatic logic [7:0] thr(input int i);
      return (i == 15) ? 8'h07 : 8'(15 - i);
   endfunction

   task automatic hard_reset();
      @(negedge clk_i);
      arst_n_i = 1'b0;
      repeat (4) @(negedge clk_i);
      arst_n_i = 1'b1;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk(8'(data_oe_o), 8'h00);
      chk(period_count_o, 8'h00);
      rdc(FMR_REG_COEF, 8'h04);
      rdc(FMR_REG_CTRL0, 8'h00);
      rdc(4'h5, 8'h00);
      $display("t_reset done");
   endtask

   task automatic t_thresh();
      logic [7:0] d;
      logic       oe;
      wr(FMR_REG_CTRL1, 8'h00);
      wr(FMR_REG_CTRL0, 8'h80);
      for (int i = 0; i < 16; i++) wr(FMR_REG_THRESH, thr(i));
      wr(FMR_REG_CTRL0, 8'h80);
      i_fmr_host_model.rd(FMR_REG_THRESH, d, oe);
      chk(8'(oe), 8'h01);
      chk(d, thr(0));
      for (int i = 1; i < 17; i++) rdc(FMR_REG_THRESH, thr(i % 16));
      wr(FMR_REG_CTRL0, 8'h80);
      for (int i = 0; i < 3; i++) rdc(FMR_REG_THRESH, thr(i));
      wr(FMR_REG_CTRL0, 8'h00);
      rdc(FMR_REG_THRESH, thr(3));
      wr(FMR_REG_CTRL1, 8'h10);
      rdc(FMR_REG_THRESH, 8'h00);
      wr(FMR_REG_CTRL1, 8'h00);
      rdc(FMR_REG_THRESH, thr(4));
      $display("t_thresh done");
   endtask

   task automatic t_corr();
      logic [8:0] a [3] = '{9'h000, 9'h12F, 9'h0A5};
      logic [4:0] v [3] = '{5'h15, 5'h0A, 5'h1F};
      i_fmr_host_model.corr_mode(1'b1);
      for (int i = 0; i < 3; i++) begin
         i_fmr_host_model.set_corr_addr(a[i], 1'b1);
         wr(FMR_REG_CORR, {3'h7, v[i]});
      end
      for (int i = 0; i < 3; i++) begin
         i_fmr_host_model.set_corr_addr(a[i], 1'b1);
         rdc(FMR_REG_CORR, {3'h0, v[i]});
      end
      i_fmr_host_model.set_corr_addr(9'h000, 1'b0);
      wr(FMR_REG_CORR, 8'h03);
      i_fmr_host_model.set_corr_addr(9'h000, 1'b1);
      rdc(FMR_REG_CORR, 8'h15);
      i_fmr_host_model.corr_mode(1'b0);
      rdc(FMR_REG_CORR, 8'h00);
      $display("t_corr done");
   endtask

   task automatic t_line();
      logic [7:0] p;
      wr(FMR_REG_CTRL0, 8'h01);
      line_step(1'b1, 1'b0, 5'h00);
      chk(8'(line_active_o), 8'h01);
      line_step(1'b0, 1'b1, 5'd20);
      chk(8'(peak_o), 8'd20);
      chk(8'(black_o), 8'h00);
      line_step(1'b0, 1'b1, 5'd12);
      chk(8'(black_o), 8'h00);
      wr(FMR_REG_COEF, 8'h07);
      line_step(1'b0, 1'b1, 5'd12);
      chk(8'(black_o), 8'h01);
      line_step(1'b0, 1'b1, 5'd25);
      chk(8'(peak_o), 8'd25);
      chk(8'(correction_apply_o), 8'h01);
      wr(FMR_REG_CTRL0, 8'h49);
      // The apply flag follows the register one cycle after the write lands
      @(negedge clk_i);
      chk(8'(correction_apply_o), 8'h00);
      wr(FMR_REG_CTRL0, 8'h09);
      @(negedge clk_i);
      chk(8'(correction_apply_o), 8'h01);
      fork
         wr(FMR_REG_CTRL0, 8'h81);
         begin
            repeat (2) @(negedge clk_i);
            chk(8'(soft_reset_o), 8'h01);
         end
      join
      chk(8'(line_active_o), 8'h00);
      chk(8'(soft_reset_o), 8'h00);
      p = period_count_o;
      line_step(1'b1, 1'b0, 5'h00);
      chk(8'(line_active_o), 8'h01);
      chk(period_count_o, p + 8'h01);
      wr(FMR_REG_CTRL1, 8'h02);
      for (int i = 0; i < 4; i++) begin
         line_step(1'b1, 1'b0, 5'h00);
         chk(8'(line_active_o), 8'((i + 1) % 2));
         // Rising pixels: a skipped line must leave the peak where it was
         line_step(1'b0, 1'b1, 5'(26 + i));
         chk(8'(peak_o), 8'(26 + i - (i % 2)));
      end
      wr(FMR_REG_CTRL1, 8'h00);
      $display("t_line done");
   endtask

   task automatic t_standby();
      logic [7:0] p;
      wr(FMR_REG_CADDR_L, 8'hA8);
      line_step(1'b1, 1'b1, 5'd2);
      wr(FMR_REG_CTRL1, 8'h01);
      // Line state is cleared one cycle after the sleep bit lands
      @(negedge clk_i);
      chk(8'(line_active_o), 8'h00);
      chk(8'(peak_o), 8'h00);
      chk(8'(black_o), 8'h00);
      chk(8'(mem_standby_o), 8'h01);
      p = period_count_o;
      line_step(1'b1, 1'b1, 5'd30);
      chk(period_count_o, p);
      chk(8'(line_active_o), 8'h00);
      wr(FMR_REG_CTRL1, 8'h00);
      chk(8'(mem_standby_o), 8'h00);
      rdc(FMR_REG_CADDR_L, 8'hA8);
      rdc(FMR_REG_COEF, 8'h07);
      rdc(FMR_REG_THRESH, thr(0));
      $display("t_standby done");
   endtask

   task automatic t_hard_reset();
      line_step(1'b1, 1'b0, 5'h00);
      hard_reset();
      chk(period_count_o, 8'h00);
      chk(8'(line_active_o), 8'h00);
      chk(8'(peak_o), 8'h00);
      rdc(FMR_REG_COEF, 8'h04);
      rdc(FMR_REG_CADDR_L, 8'h00);
      rdc(FMR_REG_THRESH, 8'h00);
      $display("t_hard_reset done");
   endtask

   // ---------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("Counts: compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Whole run needs well under a thousand cycles; the ceiling leaves margin
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         give_verdict();
      end
   end

   initial begin
      repeat (4) @(negedge clk_i);
      arst_n_i = 1'b1;
      t_reset();
      t_thresh();
      t_corr();
      t_line();
      t_standby();
      t_hard_reset();
      give_verdict();
   end

endmodule

`default_nettype wire
